// ==== design/ptmr_top.sv ====
// Purpose: pair of 16-bit timers that chain into one 32-bit timer
// Assumes: i_clk is the oscillator; internal count clock is i_clk/2
// Notes: register bus is word indexed, read data one cycle later

`timescale 1ns/10ps
`default_nettype none

module ptmr_top
	import ptmr_pkg::*;
#(
	parameter bit HAS_ADC_TRIG = 1'b1
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register bus
	input wire ptmr_pkg::ptmr_bus_type i_bus,
	output logic [ptmr_pkg::DATA_W-1:0] o_rdata,
	// pins and device state
	input wire logic i_lower_external_clock_pin,
	input wire logic i_upper_external_clock_pin,
	input wire logic i_idle,
	// events
	output logic o_irq,
	output logic o_adc_trig
);

	logic [15:0] lower_timer_control_reg;
	logic [15:0] upper_timer_control_reg;
	logic [15:0] lower_count_register_reg;
	logic [15:0] upper_count_register_reg;
	logic [15:0] lower_period_reg;
	logic [15:0] upper_period_reg;
	logic [1:0] int_status_reg;
	logic [1:0] int_mask_reg;
	logic int_phase_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] pins;
	logic pair_wide_mode;
	ptmr_cfg_type cfg [2];
	logic [1:0] active;
	logic [1:0] gated;
	logic [1:0] src_tick;
	logic [1:0] ps_in;
	logic [1:0] tick;
	logic [1:0] gate_fall;
	logic wr_lower_count;
	logic wr_upper_count;
	logic match_lower;
	logic match_upper;
	logic match_wide;
	logic [1:0] int_event;
	logic [1:0] int_status_next;
	logic adc_trig_next;
	logic [15:0] rdata_next;

	assign pins = {i_upper_external_clock_pin, i_lower_external_clock_pin};
	assign pair_wide_mode = lower_timer_control_reg[PAIR_WIDE_BIT];
	assign wr_lower_count = i_bus.wr && (i_bus.addr == LOWER_COUNT_ADDR);
	assign wr_upper_count = i_bus.wr && (i_bus.addr == UPPER_COUNT_ADDR);

	// internal count clock at half the oscillator
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			int_phase_reg <= 1'b0;
		else
			int_phase_reg <= ~int_phase_reg;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pin_prev_reg <= 2'b00;
		else
			pin_prev_reg <= pins;
	end

	// per-timer configuration, clock source, gate and prescaler
	for (genvar t = 0; t < 2; t++)
	begin : g_timer
		// upper register ignored in wide mode
		logic [15:0] ctrl;
		assign ctrl = (t == 1 && !pair_wide_mode) ? upper_timer_control_reg
			: lower_timer_control_reg;
		assign cfg[t].run = ctrl[RUN_ENABLE_BIT];
		assign cfg[t].idle_stop = ctrl[IDLE_STOP_BIT];
		assign cfg[t].gate_en = ctrl[GATE_EN_BIT];
		assign cfg[t].prescale_select = ctrl[PRESCALE_LSB+1:PRESCALE_LSB];
		assign cfg[t].clock_source_select = ctrl[CLOCK_SOURCE_BIT];
		assign active[t] = cfg[t].run && !(cfg[t].idle_stop && i_idle)
			&& !(t == 1 && pair_wide_mode);
		assign gated[t] = cfg[t].gate_en && !cfg[t].clock_source_select;
		// external rising edge or internal clock
		assign src_tick[t] = cfg[t].clock_source_select ? (pins[t] && !pin_prev_reg[t])
			: int_phase_reg;
		assign ps_in[t] = active[t] && src_tick[t] && (!gated[t] || pins[t]);
		assign gate_fall[t] = active[t] && gated[t] && pin_prev_reg[t] && !pins[t];
		// divide by 1, 8, 64 or 256
		ptmr_prescale u_prescale (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_clr(!active[t]),
			.i_sel(cfg[t].prescale_select),
			.i_tick(ps_in[t]),
			.o_tick(tick[t])
		);
	end

	assign match_lower = lower_count_register_reg == lower_period_reg;
	assign match_upper = upper_count_register_reg == upper_period_reg;
	assign match_wide = match_lower && match_upper;

	// lower word, 16-bit or low half of pair
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			lower_count_register_reg <= COUNT_RESET;
		else if (wr_lower_count)
			lower_count_register_reg <= i_bus.wdata;
		else if (tick[0])
		begin
			if (pair_wide_mode ? match_wide : match_lower)
				lower_count_register_reg <= COUNT_RESET;
			else
				lower_count_register_reg <= lower_count_register_reg + 16'h0001;
		end
	end

	// upper word carries from lower in wide mode
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			upper_count_register_reg <= COUNT_RESET;
		else if (wr_upper_count)
			upper_count_register_reg <= i_bus.wdata;
		else if (pair_wide_mode && tick[0])
		begin
			if (match_wide)
				upper_count_register_reg <= COUNT_RESET;
			else if (lower_count_register_reg == 16'hFFFF)
				upper_count_register_reg <= upper_count_register_reg + 16'h0001;
		end
		else if (!pair_wide_mode && tick[1])
		begin
			if (match_upper)
				upper_count_register_reg <= COUNT_RESET;
			else
				upper_count_register_reg <= upper_count_register_reg + 16'h0001;
		end
	end

	// flag events, wide mode on upper flag
	always_comb
	begin
		int_event = 2'b00;
		if (pair_wide_mode)
			int_event[UPPER_EVENT_BIT] = (tick[0] && match_wide) || gate_fall[0];
		else
		begin
			int_event[LOWER_EVENT_BIT] = (tick[0] && match_lower) || gate_fall[0];
			int_event[UPPER_EVENT_BIT] = (tick[1] && match_upper) || gate_fall[1];
		end
	end

	// set wins over write-one-to-clear
	always_comb
	begin
		int_status_next = int_status_reg;
		if (i_bus.wr && i_bus.addr == INT_STATUS_ADDR)
			int_status_next = int_status_reg & ~i_bus.wdata[1:0];
		int_status_next = int_status_next | int_event;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			int_status_reg <= INT_RESET;
		else
			int_status_reg <= int_status_next;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(int_status_reg & int_mask_reg);
	end

	// trigger only on the upper event flag, in both modes
	assign adc_trig_next = HAS_ADC_TRIG && int_event[UPPER_EVENT_BIT];

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_adc_trig <= 1'b0;
		else
			o_adc_trig <= adc_trig_next;
	end

	// control registers, reset zero except periods all ones, unimplemented bits dropped
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lower_timer_control_reg <= CTRL_RESET;
			upper_timer_control_reg <= CTRL_RESET;
			lower_period_reg <= PERIOD_RESET;
			upper_period_reg <= PERIOD_RESET;
			int_mask_reg <= INT_RESET;
		end
		else if (i_bus.wr)
		begin
			if (i_bus.addr == LOWER_CTRL_ADDR)
				lower_timer_control_reg <= i_bus.wdata & LOWER_CTRL_MASK;
			else if (i_bus.addr == UPPER_CTRL_ADDR)
				upper_timer_control_reg <= i_bus.wdata & UPPER_CTRL_MASK;
			else if (i_bus.addr == LOWER_PERIOD_ADDR)
				lower_period_reg <= i_bus.wdata;
			else if (i_bus.addr == UPPER_PERIOD_ADDR)
				upper_period_reg <= i_bus.wdata;
			else if (i_bus.addr == INT_MASK_ADDR)
				int_mask_reg <= i_bus.wdata[1:0];
		end
	end

	// read decode, unmapped reads zero
	always_comb
	begin
		if (i_bus.addr == LOWER_CTRL_ADDR)
			rdata_next = lower_timer_control_reg;
		else if (i_bus.addr == UPPER_CTRL_ADDR)
			rdata_next = upper_timer_control_reg;
		else if (i_bus.addr == LOWER_COUNT_ADDR)
			rdata_next = lower_count_register_reg;
		else if (i_bus.addr == UPPER_COUNT_ADDR)
			rdata_next = upper_count_register_reg;
		else if (i_bus.addr == LOWER_PERIOD_ADDR)
			rdata_next = lower_period_reg;
		else if (i_bus.addr == UPPER_PERIOD_ADDR)
			rdata_next = upper_period_reg;
		else if (i_bus.addr == INT_STATUS_ADDR)
			rdata_next = {14'h0000, int_status_reg};
		else if (i_bus.addr == INT_MASK_ADDR)
			rdata_next = {14'h0000, int_mask_reg};
		else
			rdata_next = 16'h0000;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= 16'h0000;
		else if (i_bus.rd)
			o_rdata <= rdata_next;
		else
			o_rdata <= 16'h0000;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_wide_stop;
		pair_wide_mode && !cfg[0].run && !wr_lower_count && !wr_upper_count
			|=> $stable(lower_count_register_reg) && $stable(upper_count_register_reg);
	endproperty
	a_wide_stop: assert property (p_wide_stop) else $error("pair counted while stopped");

	property p_upper_stop;
		!pair_wide_mode && !upper_timer_control_reg[RUN_ENABLE_BIT] && !wr_upper_count
			|=> $stable(upper_count_register_reg);
	endproperty
	a_upper_stop: assert property (p_upper_stop) else $error("upper counted while off");

	property p_idle_stop;
		i_idle && cfg[0].idle_stop |-> !tick[0];
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("tick during idle stop");

	property p_prescale8;
		tick[0] && cfg[0].prescale_select == 2'b01 && $stable(lower_timer_control_reg)
			|=> !tick[0] [*8];
	endproperty
	a_prescale8: assert property (p_prescale8) else $error("1:8 prescale too fast");

	property p_wide_upper_quiet;
		pair_wide_mode |-> !tick[1];
	endproperty
	a_wide_upper_quiet: assert property (p_wide_upper_quiet) else $error("upper ran in wide");

	property p_internal_phase;
		tick[0] && !cfg[0].clock_source_select |-> int_phase_reg;
	endproperty
	a_internal_phase: assert property (p_internal_phase) else $error("internal tick off phase");

	property p_period_wrap;
		!pair_wide_mode && tick[0] && match_lower && !wr_lower_count
			|=> lower_count_register_reg == 16'h0000 && int_status_reg[LOWER_EVENT_BIT];
	endproperty
	a_period_wrap: assert property (p_period_wrap) else $error("no wrap at period");

	property p_wide_flag;
		pair_wide_mode && tick[0] && match_wide |=> int_status_reg[UPPER_EVENT_BIT]
			##1 o_irq || !int_mask_reg[UPPER_EVENT_BIT];
	endproperty
	a_wide_flag: assert property (p_wide_flag) else $error("wide match not flagged");

	property p_gate_fall;
		gated[0] && active[0] && $fell(i_lower_external_clock_pin)
			|=> int_status_reg[pair_wide_mode ? UPPER_EVENT_BIT : LOWER_EVENT_BIT];
	endproperty
	a_gate_fall: assert property (p_gate_fall) else $error("gate fall not flagged");

	property p_ctrl_read;
		i_bus.rd && i_bus.addr == LOWER_CTRL_ADDR |=> (o_rdata & ~LOWER_CTRL_MASK) == 16'h0000;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("unimplemented bit set");

	c_wide_match: cover property (pair_wide_mode && tick[0] && match_wide);
	c_gate_fall: cover property (gate_fall[0]);
	c_idle_hold: cover property (i_idle && cfg[1].idle_stop && cfg[1].run);
	c_ps256: cover property (tick[1] && cfg[1].prescale_select == 2'b11);

endmodule

`default_nettype wire

// ==== design/ptmr_pkg.sv ====
// Purpose: shared constants and types of the pairable 16/32-bit timer
// Assumes: 16-bit register bus, word indexed
// Notes: unimplemented control bits read as zero

package ptmr_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// register indices
	localparam logic [3:0] LOWER_CTRL_ADDR = 4'h0;
	localparam logic [3:0] UPPER_CTRL_ADDR = 4'h1;
	localparam logic [3:0] LOWER_COUNT_ADDR = 4'h2;
	localparam logic [3:0] UPPER_COUNT_ADDR = 4'h3;
	localparam logic [3:0] LOWER_PERIOD_ADDR = 4'h4;
	localparam logic [3:0] UPPER_PERIOD_ADDR = 4'h5;
	localparam logic [3:0] INT_STATUS_ADDR = 4'h6;
	localparam logic [3:0] INT_MASK_ADDR = 4'h7;

	// control field positions
	localparam int RUN_ENABLE_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int GATE_EN_BIT = 6;
	localparam int PRESCALE_LSB = 4;
	localparam int PAIR_WIDE_BIT = 3;
	localparam int CLOCK_SOURCE_BIT = 1;

	// implemented bits of each control register
	localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
	localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [1:0] INT_RESET = 2'b00;

	// interrupt status bits
	localparam int LOWER_EVENT_BIT = 0;
	localparam int UPPER_EVENT_BIT = 1;

	// prescale terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PS_LIMIT_1 = 8'h00;
	localparam logic [7:0] PS_LIMIT_8 = 8'h07;
	localparam logic [7:0] PS_LIMIT_64 = 8'h3F;
	localparam logic [7:0] PS_LIMIT_256 = 8'hFF;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ptmr_bus_type;

	typedef struct packed {
		logic run;
		logic idle_stop;
		logic gate_en;
		logic [1:0] prescale_select;
		logic clock_source_select;
	} ptmr_cfg_type;

endpackage

// ==== design/ptmr_prescale.sv ====
// Purpose: input clock prescaler for one timer
// Assumes: i_tick is a one-cycle pulse
// Notes: count restarts whenever the timer is not active

`timescale 1ns/10ps
`default_nettype none

module ptmr_prescale
	import ptmr_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// control
	input wire logic i_clr,
	input wire logic [1:0] i_sel,
	// ticks
	input wire logic i_tick,
	output logic o_tick
);

	logic [7:0] cnt_reg;
	logic [7:0] limit;

	always_comb
	begin
		case (i_sel)
			2'b00: limit = PS_LIMIT_1;
			2'b01: limit = PS_LIMIT_8;
			2'b10: limit = PS_LIMIT_64;
			default: limit = PS_LIMIT_256;
		endcase
	end

	assign o_tick = i_tick && (cnt_reg >= limit);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_reg <= 8'h00;
		else if (i_clr || o_tick)
			cnt_reg <= 8'h00;
		else if (i_tick)
			cnt_reg <= cnt_reg + 8'h01;
	end

endmodule

`default_nettype wire

// ==== testbench/ptmr_top_test.sv ====
// Purpose: self-checking bench of the pairable 16/32-bit timer
// Assumes: external clock pins give exact tick counts; internal clock ticks every other cycle
// Notes: tests are sequences of register accesses with expected values

`timescale 1ns/10ps
`default_nettype none

module ptmr_top_test;
	import ptmr_pkg::*;

	logic clk;
	logic rst_n;
	ptmr_bus_type bus;
	logic [DATA_W-1:0] rdata;
	logic lo_pin;
	logic up_pin;
	logic idle;
	logic irq;
	logic adc;
	int n_adc = 0;
	int n_mismatch;
	int total_checks;
	int divs[4] = '{1, 8, 64, 256};
	logic [15:0] v;

	ptmr_top #(.HAS_ADC_TRIG(1'b1)) i_ptmr_top (
		.i_clk(clk),
		.i_rst_n(rst_n),
		.i_bus(bus),
		.o_rdata(rdata),
		.i_lower_external_clock_pin(lo_pin),
		.i_upper_external_clock_pin(up_pin),
		.i_idle(idle),
		.o_irq(irq),
		.o_adc_trig(adc)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
		if (adc === 1'b1)
			n_adc++;

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
		chk(name, exp, v);
	endtask

	// one rising edge per pulse on the chosen pin
	task automatic pulse(input logic up, input int n);
		repeat (n)
		begin
			@(posedge clk);
			lo_pin <= !up;
			up_pin <= up;
			repeat (2) @(posedge clk);
			lo_pin <= 1'b0;
			up_pin <= 1'b0;
			@(posedge clk);
		end
	endtask

	initial
	begin
		rst_n = 1'b0;
		bus = '0;
		lo_pin = 1'b0;
		up_pin = 1'b0;
		idle = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;

		rchk("lower ctrl reset", LOWER_CTRL_ADDR, 16'h0000);
		rchk("upper ctrl reset", UPPER_CTRL_ADDR, 16'h0000);
		wr(LOWER_CTRL_ADDR, 16'hFFFF);
		rchk("lower ctrl mask", LOWER_CTRL_ADDR, 16'hA07A);
		wr(UPPER_CTRL_ADDR, 16'hFFFF);
		rchk("upper ctrl mask", UPPER_CTRL_ADDR, 16'hA072);
		wr(LOWER_CTRL_ADDR, 16'h0000);
		wr(UPPER_CTRL_ADDR, 16'h0000);
		wr(4'h9, 16'hFFFF);
		rchk("unmapped", 4'h9, 16'h0000);
		wr(LOWER_COUNT_ADDR, 16'h0000);
		wr(UPPER_COUNT_ADDR, 16'h0000);
		wr(INT_STATUS_ADDR, 16'h0003);
		$display("test registers done");

		for (int c = 0; c < 4; c++)
		begin
			wr(LOWER_CTRL_ADDR, 16'h0002);
			wr(LOWER_COUNT_ADDR, 16'h0000);
			wr(LOWER_CTRL_ADDR, 16'h8002 | (16'(c) << 4));
			pulse(1'b0, 3 * divs[c]);
			rchk("prescaled count", LOWER_COUNT_ADDR, 16'h0003);
		end
		rchk("upper untouched", UPPER_COUNT_ADDR, 16'h0000);
		$display("test prescale done");

		wr(LOWER_CTRL_ADDR, 16'h0002);
		wr(UPPER_COUNT_ADDR, 16'h0000);
		wr(UPPER_CTRL_ADDR, 16'h8002);
		pulse(1'b1, 3);
		pulse(1'b0, 2);
		rchk("upper alone", UPPER_COUNT_ADDR, 16'h0003);
		rchk("lower stopped", LOWER_COUNT_ADDR, 16'h0003);
		wr(UPPER_CTRL_ADDR, 16'h0002);
		pulse(1'b1, 2);
		rchk("upper stopped", UPPER_COUNT_ADDR, 16'h0003);
		$display("test independent done");

		wr(LOWER_COUNT_ADDR, 16'h0000);
		wr(LOWER_PERIOD_ADDR, 16'h0003);
		wr(LOWER_CTRL_ADDR, 16'h8002);
		pulse(1'b0, 4);
		rchk("wrap to zero", LOWER_COUNT_ADDR, 16'h0000);
		rchk("lower event", INT_STATUS_ADDR, 16'h0001);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(INT_MASK_ADDR, 16'h0001);
		repeat (3) @(posedge clk);
		chk("irq unmasked", 16'h0001, {15'h0000, irq});
		wr(INT_STATUS_ADDR, 16'h0001);
		repeat (3) @(posedge clk);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		rchk("status cleared", INT_STATUS_ADDR, 16'h0000);
		wr(LOWER_PERIOD_ADDR, 16'hFFFF);
		$display("test period done");

		wr(LOWER_CTRL_ADDR, 16'hA002);
		wr(LOWER_COUNT_ADDR, 16'h0000);
		idle <= 1'b1;
		pulse(1'b0, 2);
		rchk("idle halted", LOWER_COUNT_ADDR, 16'h0000);
		@(posedge clk);
		idle <= 1'b0;
		pulse(1'b0, 2);
		wr(LOWER_CTRL_ADDR, 16'h8002);
		idle <= 1'b1;
		pulse(1'b0, 1);
		idle <= 1'b0;
		rchk("idle runs", LOWER_COUNT_ADDR, 16'h0003);
		$display("test idle done");

		wr(LOWER_CTRL_ADDR, 16'h0040);
		wr(LOWER_COUNT_ADDR, 16'h0000);
		wr(LOWER_CTRL_ADDR, 16'h8040);
		repeat (20) @(posedge clk);
		rchk("gate low", LOWER_COUNT_ADDR, 16'h0000);
		// gate high for 20 edges gives 10 internal ticks at osc/2
		@(posedge clk);
		lo_pin <= 1'b1;
		repeat (20) @(posedge clk);
		lo_pin <= 1'b0;
		repeat (4) @(posedge clk);
		wr(LOWER_CTRL_ADDR, 16'h0040);
		rchk("gate event", INT_STATUS_ADDR, 16'h0001);
		rchk("gated count", LOWER_COUNT_ADDR, 16'h000A);
		chk("internal rate", 16'h000A, v);
		wr(INT_STATUS_ADDR, 16'h0003);
		wr(LOWER_COUNT_ADDR, 16'h0000);
		wr(LOWER_CTRL_ADDR, 16'h8042);
		pulse(1'b0, 2);
		rchk("gate ignored", LOWER_COUNT_ADDR, 16'h0002);
		rchk("no gate event", INT_STATUS_ADDR, 16'h0000);
		$display("test gate done");

		wr(LOWER_CTRL_ADDR, 16'h0000);
		wr(LOWER_PERIOD_ADDR, 16'h0001);
		wr(UPPER_PERIOD_ADDR, 16'h0001);
		wr(LOWER_COUNT_ADDR, 16'hFFFE);
		wr(UPPER_COUNT_ADDR, 16'h0000);
		wr(UPPER_CTRL_ADDR, 16'h8002);
		wr(LOWER_CTRL_ADDR, 16'h800A);
		pulse(1'b0, 2);
		rchk("wide low word", LOWER_COUNT_ADDR, 16'h0000);
		rchk("wide high word", UPPER_COUNT_ADDR, 16'h0001);
		pulse(1'b1, 3);
		rchk("upper ctrl ignored", UPPER_COUNT_ADDR, 16'h0001);
		pulse(1'b0, 2);
		rchk("wide wrap low", LOWER_COUNT_ADDR, 16'h0000);
		rchk("wide wrap high", UPPER_COUNT_ADDR, 16'h0000);
		rchk("upper event", INT_STATUS_ADDR, 16'h0002);
		chk("adc trigger", 16'h0001, 16'(n_adc));
		wr(LOWER_CTRL_ADDR, 16'h000A);
		pulse(1'b0, 2);
		rchk("wide stopped", LOWER_COUNT_ADDR, 16'h0000);
		$display("test wide done");
		give_verdict();
	end

	initial
	begin
		#200000;
		n_mismatch++;
		give_verdict();
	end

endmodule

`default_nettype wire
